// *** rtl/boot_mode_ctrl.sv ***
// boot mode selection after reset and reduced-power run control
`timescale 1ns/1ps
module boot_mode_ctrl
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         por_reset,
  // mode pins
  input  wire logic         boot_select_pin,
  input  wire logic         debug_mode_select_pin,
  output logic              boot_pin_out,
  output logic              boot_pin_oe_n,
  output logic              boot_pin_pullup,
  // flash read port
  output logic              flash_rd,
  output logic [15:0]       flash_addr,
  input  wire logic [7:0]   flash_rdata,
  // mode result
  output boot_mode_pkg::mode_t mode,
  output logic              mode_valid,
  output logic              cpu_start,
  output logic [15:0]       start_vector,
  output logic              partial_erase_allowed,
  // power control
  input  wire logic         irq_pending,
  output logic              regulator_standby,
  output logic              low_voltage_detect_active,
  output logic              low_voltage_warning_active,
  // apb
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] boot_sync;
  logic [1:0] dbg_sync;

  always_ff @(posedge core_clk)
  begin
    boot_sync <= {boot_sync[0], boot_select_pin};
    dbg_sync  <= {dbg_sync[0], debug_mode_select_pin};
  end

  // ----------------------------------------
  // crc step
  // ----------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      c = c[15] ? ((c << 1) ^ boot_mode_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  boot_mode_pkg::seq_t state;
  logic [4:0]  settle_cnt;
  logic        rd_wait;
  logic        por_seen;
  logic        sampled_boot_select;
  logic        sampled_debug;
  logic [7:0]  bypass_byte;
  logic [7:0]  erase_byte;
  logic [15:0] stored_flash_checksum;
  logic [15:0] crc_value;
  logic        crc_ran;
  logic [7:0]  boot_reentry_semaphore;
  logic [4:0]  ctrl;
  logic        reduced_power_request;
  logic        regulator_standby_status;
  logic        got;

  assign got = rd_wait;

  // flash reads: strobe and address registered together, data taken in that same cycle
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      flash_rd   <= 1'b0;
      flash_addr <= 16'h0000;
      rd_wait    <= 1'b0;
    end
    else
    begin
      flash_rd <= 1'b0;
      rd_wait  <= 1'b0;
      if (!rd_wait && state inside {boot_mode_pkg::S_ERASE, boot_mode_pkg::S_BYPASS,
          boot_mode_pkg::S_CRC_HI, boot_mode_pkg::S_CRC_LO, boot_mode_pkg::S_SCAN})
      begin
        flash_rd <= 1'b1;
        rd_wait  <= 1'b1;
        case (state)
          boot_mode_pkg::S_ERASE:  flash_addr <= boot_mode_pkg::LOC_ERASE;
          boot_mode_pkg::S_BYPASS: flash_addr <= boot_mode_pkg::LOC_BYPASS;
          boot_mode_pkg::S_CRC_HI: flash_addr <= boot_mode_pkg::LOC_CRC_HI;
          boot_mode_pkg::S_CRC_LO: flash_addr <= boot_mode_pkg::LOC_CRC_LO;
          boot_mode_pkg::S_SCAN:
          begin
            if (!crc_ran)
              flash_addr <= boot_mode_pkg::CRC_FIRST;
            else
              flash_addr <= flash_addr + 16'h0001;
          end
          default: flash_addr <= flash_addr;
        endcase
      end
    end
  end

  // mode sequence, latched once per reset
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state                 <= boot_mode_pkg::S_SETTLE;
      settle_cnt            <= 5'h00;
      por_seen              <= 1'b0;
      sampled_boot_select   <= 1'b1;
      sampled_debug         <= 1'b1;
      bypass_byte           <= 8'h00;
      erase_byte            <= 8'hFF;
      stored_flash_checksum <= 16'h0000;
      crc_value             <= boot_mode_pkg::CRC_INIT;
      crc_ran               <= 1'b0;
      mode                  <= boot_mode_pkg::MODE_PENDING;
      mode_valid            <= 1'b0;
      cpu_start             <= 1'b0;
    end
    else
    begin
      cpu_start <= 1'b0;
      case (state)
        boot_mode_pkg::S_SETTLE:
        begin
          if (settle_cnt == 5'h00)
            por_seen <= por_reset;
          settle_cnt <= settle_cnt + 5'h01;
          if (settle_cnt == 5'(boot_mode_pkg::SETTLE_CYC - 1))
          begin
            sampled_boot_select <= boot_sync[1];
            sampled_debug       <= dbg_sync[1];
            state               <= boot_mode_pkg::S_ERASE;
          end
        end
        boot_mode_pkg::S_ERASE:
          if (got)
          begin
            erase_byte <= flash_rdata;
            state      <= boot_mode_pkg::S_DECIDE;
          end
        boot_mode_pkg::S_DECIDE:
        begin
          state <= boot_mode_pkg::S_DONE;
          if (!por_seen)
            mode <= (boot_reentry_semaphore == boot_mode_pkg::SEMA_BOOT) ?
                    boot_mode_pkg::MODE_BOOT : boot_mode_pkg::MODE_USER;
          else if (!sampled_boot_select && !sampled_debug)
            mode <= boot_mode_pkg::MODE_BACKGROUND;
          else if (!sampled_boot_select)
            mode <= boot_mode_pkg::MODE_BOOT;
          else
            state <= boot_mode_pkg::S_BYPASS;
        end
        boot_mode_pkg::S_BYPASS:
          if (got)
          begin
            bypass_byte <= flash_rdata;
            state       <= boot_mode_pkg::S_DONE;
            if (flash_rdata == boot_mode_pkg::BYTE_ZERO)
              mode <= boot_mode_pkg::MODE_USER;
            else if (flash_rdata != boot_mode_pkg::BYTE_ERASED)
              mode <= boot_mode_pkg::MODE_BOOT;
            else
              state <= boot_mode_pkg::S_CRC_HI;
          end
        boot_mode_pkg::S_CRC_HI:
          if (got)
          begin
            stored_flash_checksum[15:8] <= flash_rdata;
            state                       <= boot_mode_pkg::S_CRC_LO;
          end
        boot_mode_pkg::S_CRC_LO:
          if (got)
          begin
            stored_flash_checksum[7:0] <= flash_rdata;
            state                      <= boot_mode_pkg::S_SCAN;
          end
        boot_mode_pkg::S_SCAN:
          if (got)
          begin
            crc_ran   <= 1'b1;
            crc_value <= crc_step(crc_value, flash_rdata);
            if (flash_addr == boot_mode_pkg::CRC_LAST)
            begin
              state <= boot_mode_pkg::S_DONE;
              mode  <= (crc_step(crc_value, flash_rdata) == stored_flash_checksum) ?
                       boot_mode_pkg::MODE_USER : boot_mode_pkg::MODE_BOOT;
            end
          end
        boot_mode_pkg::S_DONE:
        begin
          mode_valid <= 1'b1;
          cpu_start  <= !mode_valid && (mode == boot_mode_pkg::MODE_USER);
        end
        default: state <= boot_mode_pkg::S_SETTLE;
      endcase
    end
  end

  assign start_vector          = boot_mode_pkg::RESET_VEC;
  assign partial_erase_allowed = mode_valid && (erase_byte == boot_mode_pkg::BYTE_ZERO);

  // ----------------------------------------
  // boot pin: pull-up until decided, then output
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      boot_pin_pullup <= 1'b1;
      boot_pin_oe_n   <= 1'b1;
      boot_pin_out    <= 1'b0;
    end
    else
    begin
      boot_pin_pullup <= !mode_valid;
      boot_pin_oe_n   <= !mode_valid;
      boot_pin_out    <= ctrl[boot_mode_pkg::CTRL_PIN];
    end
  end

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  logic wr_en;
  logic mapped;

  assign wr_en   = psel && penable && pwrite;
  assign mapped  = paddr inside {boot_mode_pkg::ADDR_CTRL, boot_mode_pkg::ADDR_STATUS,
                                 boot_mode_pkg::ADDR_SEMA, boot_mode_pkg::ADDR_CRC};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // semaphore survives every reset except power-on
  always_ff @(posedge core_clk)
  begin
    if (!reset_n && por_reset)
      boot_reentry_semaphore <= 8'h00;
    else if (reset_n && wr_en && paddr == boot_mode_pkg::ADDR_SEMA)
      boot_reentry_semaphore <= pwdata[7:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      ctrl <= boot_mode_pkg::CTRL_RESET;
    else if (wr_en && paddr == boot_mode_pkg::ADDR_CTRL)
      ctrl <= pwdata[4:0];
  end

  // request and standby status
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      reduced_power_request    <= 1'b0;
      regulator_standby_status <= 1'b0;
    end
    else if (wr_en && paddr == boot_mode_pkg::ADDR_CTRL)
    begin
      reduced_power_request    <= pwdata[boot_mode_pkg::CTRL_REQ];
      regulator_standby_status <= reduced_power_request;
    end
    else if (irq_pending && ctrl[boot_mode_pkg::CTRL_WAKE])
    begin
      reduced_power_request    <= 1'b0;
      regulator_standby_status <= 1'b0;
    end
    else
      regulator_standby_status <= reduced_power_request;
  end

  assign regulator_standby = regulator_standby_status;
  assign low_voltage_detect_active  = ctrl[boot_mode_pkg::CTRL_LOW_VOLTAGE_DETECT_ENABLE] &&
                                      !regulator_standby_status;
  assign low_voltage_warning_active = ctrl[boot_mode_pkg::CTRL_LOW_VOLTAGE_DETECT_ENABLE] &&
                                      !regulator_standby_status;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      case (paddr)
        boot_mode_pkg::ADDR_CTRL:
          prdata <= {27'h0, ctrl[4:1], reduced_power_request};
        boot_mode_pkg::ADDR_STATUS:
          prdata <= {24'h0, crc_ran, partial_erase_allowed, por_seen, sampled_debug,
                     sampled_boot_select, mode, regulator_standby_status};
        boot_mode_pkg::ADDR_SEMA:
          prdata <= {24'h0, boot_reentry_semaphore};
        boot_mode_pkg::ADDR_CRC:
          prdata <= {stored_flash_checksum, crc_value};
        default:
          prdata <= 32'h0000_0000;
      endcase
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence decide_pins(logic b, logic d);
    state == boot_mode_pkg::S_DECIDE && por_seen && sampled_boot_select == b &&
    sampled_debug == d;
  endsequence

  sequence wake_hit;
    irq_pending && ctrl[boot_mode_pkg::CTRL_WAKE] && reduced_power_request &&
    !(wr_en && paddr == boot_mode_pkg::ADDR_CTRL);
  endsequence

  a_boot_pin_low: assert property (decide_pins(1'b0, 1'b1) |=> mode == boot_mode_pkg::MODE_BOOT)
    else $error("boot pin low did not select bootloader");
  a_bypass_other: assert property ($rose(mode_valid) && por_seen && sampled_boot_select &&
    sampled_debug && bypass_byte != 8'h00 && bypass_byte != 8'hFF |->
    mode == boot_mode_pkg::MODE_BOOT)
    else $error("odd bypass byte did not select bootloader");
  a_crc_verdict: assert property ($rose(mode_valid) && crc_ran |->
    mode == ((crc_value == stored_flash_checksum) ? boot_mode_pkg::MODE_USER :
    boot_mode_pkg::MODE_BOOT))
    else $error("crc verdict wrong");
  a_bypass_zero: assert property ($rose(mode_valid) && por_seen && sampled_boot_select &&
    sampled_debug && bypass_byte == 8'h00 |-> mode == boot_mode_pkg::MODE_USER && !crc_ran)
    else $error("zero bypass byte not honoured");
  a_sema_check: assert property (state == boot_mode_pkg::S_DECIDE && !por_seen |=>
    mode == ((boot_reentry_semaphore == 8'hC3) ? boot_mode_pkg::MODE_BOOT :
    boot_mode_pkg::MODE_USER))
    else $error("semaphore check wrong");
  a_both_low: assert property (decide_pins(1'b0, 1'b0) |=>
    mode == boot_mode_pkg::MODE_BACKGROUND)
    else $error("background mode not chosen");
  a_crc_range: assert property (state == boot_mode_pkg::S_SCAN && flash_rd |->
    flash_addr >= 16'h1000 && flash_addr <= 16'hFB00)
    else $error("crc read out of range");
  a_erase_gate: assert property (partial_erase_allowed |-> erase_byte == 8'h00)
    else $error("partial erase allowed wrongly");
  a_user_start: assert property ($rose(mode_valid) && mode == boot_mode_pkg::MODE_USER |->
    cpu_start && start_vector == 16'hFFFE ##1 !cpu_start)
    else $error("user start wrong");
  a_lv_off: assert property (regulator_standby |-> !low_voltage_detect_active &&
    !low_voltage_warning_active)
    else $error("low voltage functions active in standby");
  a_req_standby: assert property ($rose(reduced_power_request) && !irq_pending |=>
    regulator_standby)
    else $error("standby did not follow request");
  a_stay_low: assert property (reduced_power_request && irq_pending &&
    !ctrl[boot_mode_pkg::CTRL_WAKE] && !wr_en |=> reduced_power_request)
    else $error("interrupt left reduced power without wake");
  a_wake_clear: assert property (wake_hit |=> !reduced_power_request && !regulator_standby)
    else $error("wake interrupt did not clear bits");
  a_reset_clear: assert property ($rose(reset_n) |-> !reduced_power_request &&
    !regulator_standby)
    else $error("reset did not clear reduced power");
  a_pin_release: assert property (mode_valid |=> !boot_pin_pullup && !boot_pin_oe_n)
    else $error("boot pin not released");
  a_mode_hold: assert property (mode_valid |=> mode_valid && $stable(mode))
    else $error("mode changed after decision");

endmodule

// *** rtl/boot_mode_pkg.sv ***
// constants and types for boot mode selection and reduced-power run
package boot_mode_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_SEMA   = 8'h08;
  localparam logic [7:0]  ADDR_CRC    = 8'h0C;
  localparam int          CTRL_REQ    = 0;
  localparam int          CTRL_WAKE   = 1;
  localparam int          CTRL_LOW_VOLTAGE_DETECT_ENABLE   = 2;
  localparam int          CTRL_STOP_LOW_VOLTAGE_DETECT_ENABLE  = 3;
  localparam int          CTRL_PIN    = 4;
  localparam logic [4:0]  CTRL_RESET  = 5'h0C;

  // ----------------------------------------
  // flash layout and values
  // ----------------------------------------
  localparam logic [15:0] CRC_FIRST   = 16'h1000;
  localparam logic [15:0] CRC_LAST    = 16'hFB00;
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] LOC_BYPASS  = 16'hFFB0;
  localparam logic [15:0] LOC_CRC_HI  = 16'hFFB1;
  localparam logic [15:0] LOC_CRC_LO  = 16'hFFB2;
  localparam logic [15:0] LOC_ERASE   = 16'hFFB3;
  localparam logic [15:0] RESET_VEC   = 16'hFFFE;
  localparam logic [7:0]  SEMA_BOOT   = 8'hC3;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  BYTE_ERASED = 8'hFF;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          SETTLE_CYC  = 16;

  typedef enum logic [1:0] {MODE_PENDING, MODE_BOOT, MODE_USER, MODE_BACKGROUND} mode_t;
  typedef enum logic [2:0] {S_SETTLE, S_ERASE, S_DECIDE, S_BYPASS, S_CRC_HI, S_CRC_LO,
                            S_SCAN, S_DONE} seq_t;

endpackage

// *** tb/boot_env_model.sv ***
// flash and mode-pin model facing the boot mode block
`timescale 1ns/1ps
module boot_env_model
(
  // clock
  input  wire logic        core_clk,
  // flash read port
  input  wire logic        flash_rd,
  input  wire logic [15:0] flash_addr,
  output logic [7:0]       flash_rdata,
  // flash contents under test
  input  wire logic [7:0]  bypass_byte,
  input  wire logic [7:0]  erase_byte,
  // hosts holding the pins low
  input  wire logic        host_boot_low,
  input  wire logic        host_debug_low,
  // device side of the boot pin
  input  wire logic        boot_pin_out,
  input  wire logic        boot_pin_oe_n,
  input  wire logic        boot_pin_pullup,
  output logic             boot_select_pin,
  output logic             debug_mode_select_pin
);
  logic       boot_last;
  logic [7:0] idle_data;

  initial idle_data = 8'hA5;
  initial boot_last = 1'b0;

  // ----------------------------------------
  // flash answers while the read strobe stands
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    boot_last <= boot_select_pin;
    idle_data <= ~idle_data;
  end

  // filler toggles between reads so a mistimed capture shows
  assign flash_rdata = !flash_rd ? idle_data :
                       (flash_addr == boot_mode_pkg::LOC_BYPASS) ? bypass_byte :
                       (flash_addr == boot_mode_pkg::LOC_ERASE) ? erase_byte :
                       (flash_addr[7:0] ^ flash_addr[15:8]);

  // ----------------------------------------
  // pins: pull-up, host holds low, device drives the boot pin both ways once enabled
  // ----------------------------------------
  assign debug_mode_select_pin = ~host_debug_low;
  assign boot_select_pin = !boot_pin_oe_n ? boot_pin_out :
                           host_boot_low ? 1'b0 :
                           boot_pin_pullup ? 1'b1 : ~boot_last;
endmodule

// *** tb/testbench.sv ***
// self-checking bench for boot mode choice and reduced-power run
`timescale 1ns/1ps
module testbench;
  logic                 core_clk, reset_n, por_reset, irq_pending, psel, penable, pwrite;
  logic                 host_boot_low, host_debug_low, err;
  logic [7:0]           paddr, bypass_byte, erase_byte, flash_rdata;
  logic [31:0]          pwdata, prdata, rd;
  logic                 boot_select_pin, debug_mode_select_pin, boot_pin_out, boot_pin_oe_n;
  logic                 boot_pin_pullup, flash_rd, mode_valid, cpu_start, erase_ok;
  logic                 standby, lvd_act, lvw_act, pready, pslverr;
  logic [15:0]          flash_addr, start_vector;
  boot_mode_pkg::mode_t mode;
  int                   failures, checks, cycles, starts;
  logic [19:0]          tab [6];

  boot_mode_ctrl u_dut (.core_clk(core_clk), .reset_n(reset_n), .por_reset(por_reset),
    .boot_select_pin(boot_select_pin), .debug_mode_select_pin(debug_mode_select_pin),
    .boot_pin_out(boot_pin_out), .boot_pin_oe_n(boot_pin_oe_n),
    .boot_pin_pullup(boot_pin_pullup), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata), .mode(mode), .mode_valid(mode_valid), .cpu_start(cpu_start),
    .start_vector(start_vector), .partial_erase_allowed(erase_ok),
    .irq_pending(irq_pending), .regulator_standby(standby),
    .low_voltage_detect_active(lvd_act), .low_voltage_warning_active(lvw_act),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  boot_env_model u_env (.core_clk(core_clk), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata), .bypass_byte(bypass_byte), .erase_byte(erase_byte),
    .host_boot_low(host_boot_low), .host_debug_low(host_debug_low),
    .boot_pin_out(boot_pin_out), .boot_pin_oe_n(boot_pin_oe_n),
    .boot_pin_pullup(boot_pin_pullup), .boot_select_pin(boot_select_pin),
    .debug_mode_select_pin(debug_mode_select_pin));

  // ----------------------------------------
  // clock, timeout and start-pulse monitor
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cpu_start === 1'b1)
      starts++;
    if (cycles == 6000)
    begin
      failures++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input logic por, bl, dl, input logic [7:0] byp, er);
    int n;
    n = 0;
    @(posedge core_clk);
    starts = 0;
    reset_n        <= 1'b0;
    por_reset      <= por;
    host_boot_low  <= bl;
    host_debug_low <= dl;
    bypass_byte    <= byp;
    erase_byte     <= er;
    repeat (16) @(posedge core_clk);
    check({boot_pin_pullup, boot_pin_oe_n, standby}, 3'b110);
    reset_n <= 1'b1;
    while (mode_valid !== 1'b1 && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    check(n < 200, 1'b1);
    repeat (2) @(posedge core_clk);
    host_boot_low  <= 1'b0;
    host_debug_low <= 1'b0;
    por_reset      <= 1'b0;
  endtask

  task automatic pulse_irq();
    @(posedge core_clk);
    irq_pending <= 1'b1;
    @(posedge core_clk);
    irq_pending <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_por_modes();
    logic [1:0] m;
    tab[0] = {1'b1, 1'b0, 8'hFF, 8'h00, boot_mode_pkg::MODE_BOOT};
    tab[1] = {1'b1, 1'b1, 8'hFF, 8'h00, boot_mode_pkg::MODE_BACKGROUND};
    tab[2] = {1'b0, 1'b0, 8'h5A, 8'h00, boot_mode_pkg::MODE_BOOT};
    tab[3] = {1'b0, 1'b0, 8'h01, 8'hFF, boot_mode_pkg::MODE_BOOT};
    tab[4] = {1'b0, 1'b0, 8'hFE, 8'h00, boot_mode_pkg::MODE_BOOT};
    tab[5] = {1'b0, 1'b0, 8'h00, 8'hFF, boot_mode_pkg::MODE_USER};
    for (int i = 0; i < 6; i++)
    begin
      do_reset(1'b1, tab[i][19], tab[i][18], tab[i][17:10], tab[i][9:2]);
      m = tab[i][1:0];
      check({30'h0, mode}, {30'h0, m});
      check(erase_ok, tab[i][9:2] == 8'h00);
      check(starts, m == boot_mode_pkg::MODE_USER);
      check(start_vector, 16'hFFFE);
      repeat (20) @(posedge core_clk);
      check({30'h0, mode}, {30'h0, m});
      check({boot_pin_pullup, boot_pin_oe_n}, 2'b00);
    end
  endtask

  task automatic t_crc_start();
    int n;
    n = 0;
    @(posedge core_clk);
    reset_n     <= 1'b0;
    por_reset   <= 1'b1;
    bypass_byte <= boot_mode_pkg::BYTE_ERASED;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    while (!(flash_rd === 1'b1 && flash_addr === boot_mode_pkg::CRC_FIRST) && n < 100)
    begin
      @(posedge core_clk);
      n++;
    end
    check(n < 100, 1'b1);
    por_reset <= 1'b0;
    repeat (20) @(posedge core_clk);
    check({29'h0, mode_valid, mode}, {29'h0, 1'b0, boot_mode_pkg::MODE_PENDING});
    check(flash_addr > 16'h1000 && flash_addr < 16'h1010, 1'b1);
    apb(1'b0, boot_mode_pkg::ADDR_CRC, 32'h0);
    check(rd[31:16], 16'h4E4D);
  endtask

  task automatic t_semaphore();
    apb(1'b1, boot_mode_pkg::ADDR_SEMA, 32'h0000_00C3);
    do_reset(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    check({30'h0, mode}, {30'h0, boot_mode_pkg::MODE_BOOT});
    apb(1'b1, boot_mode_pkg::ADDR_SEMA, 32'h0000_00C2);
    do_reset(1'b0, 1'b1, 1'b0, 8'h5A, 8'h00);
    check({30'h0, mode}, {30'h0, boot_mode_pkg::MODE_USER});
    check(starts, 1);
  endtask

  task automatic t_low_power();
    apb(1'b0, boot_mode_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_000C);
    apb(1'b0, 8'h10, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    // user mode only, stop detect cleared in the same write as the request
    apb(1'b1, boot_mode_pkg::ADDR_CTRL, 32'h0000_0015);
    repeat (2) @(posedge core_clk);
    check(standby, 1'b1);
    check({lvd_act, lvw_act}, 2'b00);
    check({boot_pin_out, boot_pin_oe_n, boot_select_pin}, 3'b101);
    apb(1'b0, boot_mode_pkg::ADDR_STATUS, 32'h0);
    check(rd[0], 1'b1);
    pulse_irq();
    check(standby, 1'b1);
    apb(1'b1, boot_mode_pkg::ADDR_CTRL, 32'h0000_0004);
    repeat (2) @(posedge core_clk);
    check({standby, lvd_act, lvw_act}, 3'b011);
    apb(1'b0, boot_mode_pkg::ADDR_STATUS, 32'h0);
    check(rd[0], 1'b0);
    apb(1'b1, boot_mode_pkg::ADDR_CTRL, 32'h0000_0007);
    repeat (2) @(posedge core_clk);
    check(standby, 1'b1);
    pulse_irq();
    check(standby, 1'b0);
    apb(1'b0, boot_mode_pkg::ADDR_CTRL, 32'h0);
    check(rd[1:0], 2'b10);
    apb(1'b1, boot_mode_pkg::ADDR_CTRL, 32'h0000_0005);
    repeat (2) @(posedge core_clk);
    do_reset(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    check(standby, 1'b0);
    apb(1'b0, boot_mode_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_000C);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    failures = 0;
    checks = 0;
    cycles = 0;
    starts = 0;
    reset_n = 1'b0;
    por_reset = 1'b1;
    irq_pending = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    host_boot_low = 1'b0;
    host_debug_low = 1'b0;
    bypass_byte = 8'hFF;
    erase_byte = 8'hFF;
    t_por_modes();
    t_crc_start();
    t_semaphore();
    t_low_power();
    print_verdict();
  end
endmodule
